// *** design/pdm_defines.svh ***
// program/data memory map constants
// assumes inclusion by bare name from design files
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_PC_W 13
`define PDM_WORD_W 14
`define PDM_PROG_WORDS 8192
`define PDM_RESET_VEC 13'h0000
`define PDM_IRQ_VEC 13'h0004
`define PDM_BSEL_HI 6
`define PDM_BSEL_LO 5
`define PDM_OFS_W 7
`define PDM_DADDR_W 9
`define PDM_BANK_TOP 7'h7F
`define PDM_GPR_BASE 7'h20
`define PDM_COMMON_BASE 7'h70
`define PDM_STATUS_OFS 7'h03
`define PDM_STATUS_RST 8'h00
`define PDM_RAM_DEPTH 512

`endif

// *** design/pdm_pkg.sv ***
// types shared by the memory map block
// assumes pdm_defines.svh on the include path
`include "pdm_defines.svh"
package pdm_pkg;
    typedef enum logic [1:0] {PDM_SRC_RAM, PDM_SRC_STATUS, PDM_SRC_SFR} pdm_src_t;
    typedef enum logic {PDM_PM_IDLE, PDM_PM_CAPTURE} pdm_pm_t;

    typedef struct packed {
        logic step;
        logic jump;
        logic irq;
        logic [`PDM_PC_W-1:0] target;
    } pdm_pc_ctl_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [`PDM_OFS_W-1:0] ofs;
        logic [7:0] wdata;
    } pdm_dreq_t;

    typedef struct packed {
        logic [`PDM_PC_W-1:0] pc;
        logic [7:0] status;
        logic rd_pend;
        pdm_src_t rd_src;
        logic [7:0] rd_hold;
        logic rd_ack;
        logic [7:0] rd_data;
        pdm_pm_t pm_state;
        logic [`PDM_PC_W-1:0] pm_addr;
        logic [`PDM_WORD_W-1:0] pm_data;
        logic pm_done;
    } pdm_state_t;
endpackage

// *** design/pdm_ram.sv ***
// general purpose static ram, one port, registered read
// assumes one clock, write and read addressed in the same cycle
`timescale 1ns/100ps
`include "pdm_defines.svh"
module pdm_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `PDM_RAM_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= mem[addr];
        end
    end
endmodule // pdm_ram

// *** design/pdm_map.sv ***
// program counter and data bank address mapping for a small core
// assumes core drives fetch control and data requests on clk
// Function
// - program counter is 13 bits, addressing 8K words of 14 bits
// - large variant implements 8K words, small variant 4K words
// - addresses beyond implemented program memory wrap onto it
// - reset starts fetch at program address 0000h
// - taken interrupt sends execution to program address 0004h
// - program and data memories use separate buses, usable together
// - status bits 6 and 5 select data bank 0 to 3
// - each bank spans offsets 00h to 7Fh, 128 bytes
// - special registers sit low in each bank, static ram above
// - every implemented bank holds special registers low down
// - frequently used special registers alias to one register across banks
// - user code can read program memory words internally
`timescale 1ns/100ps
`include "pdm_defines.svh"
module pdm_map #(
    parameter int PROG_WORDS = `PDM_PROG_WORDS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program counter control from core
    input wire pdm_pkg::pdm_pc_ctl_t pc_ctl,
    // instruction fetch bus
    output logic [`PDM_PC_W-1:0] fetch_addr,
    // program memory read by user code
    input wire logic pm_req,
    input wire logic [`PDM_PC_W-1:0] pm_rd_addr,
    output logic pm_busy,
    output logic [`PDM_PC_W-1:0] pm_addr,
    input wire logic [`PDM_WORD_W-1:0] pm_word,
    output logic pm_done,
    output logic [`PDM_WORD_W-1:0] pm_data,
    // data access from core
    input wire pdm_pkg::pdm_dreq_t dreq,
    output logic d_ack,
    output logic [7:0] d_rdata,
    // special register bus
    output logic sfr_re,
    output logic sfr_we,
    output logic [`PDM_DADDR_W-1:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // status and bank view
    output logic [7:0] status_q,
    output logic bank_select_high,
    output logic bank_select_low
);
    localparam logic [`PDM_PC_W-1:0] PC_MASK = `PDM_PC_W'(PROG_WORDS - 1);

    pdm_pkg::pdm_state_t s;
    pdm_pkg::pdm_state_t next_s;

    logic [1:0] bank;
    logic [`PDM_DADDR_W-1:0] daddr;
    logic is_gpr;
    logic is_status;
    logic ram_we;
    logic [7:0] ram_q;

    // fold an address onto implemented program words
    function automatic logic [`PDM_PC_W-1:0] wrap(input logic [`PDM_PC_W-1:0] a);
        return a & PC_MASK;
    endfunction

    // registers shared by all banks
    function automatic logic mirrored(input logic [`PDM_OFS_W-1:0] ofs);
        logic m;
        m = 1'b0;
        unique case (ofs)
            7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B: m = 1'b1;
            default: m = (ofs >= `PDM_COMMON_BASE);
        endcase
        return m;
    endfunction

    // full data address from bank and offset, aliases folded to bank 0
    function automatic logic [`PDM_DADDR_W-1:0] canon(input logic [1:0] b,
                                                     input logic [`PDM_OFS_W-1:0] ofs);
        return mirrored(ofs) ? {2'b00, ofs} : {b, ofs};
    endfunction

    assign bank = {s.status[`PDM_BSEL_HI], s.status[`PDM_BSEL_LO]};
    assign daddr = canon(bank, dreq.ofs);
    assign is_status = (dreq.ofs == `PDM_STATUS_OFS);
    assign is_gpr = (dreq.ofs >= `PDM_GPR_BASE) && !is_status;

    // lower offsets of every bank go to special registers
    assign ram_we = dreq.req && dreq.we && is_gpr;
    assign sfr_we = dreq.req && dreq.we && !is_gpr && !is_status;
    assign sfr_re = dreq.req && !dreq.we && !is_gpr && !is_status;
    assign sfr_addr = daddr;
    assign sfr_wdata = dreq.wdata;

    pdm_ram #(
        .WIDTH(8),
        .DEPTH(`PDM_RAM_DEPTH),
        .AW(`PDM_DADDR_W)
    ) u_gpr (
        .clk(clk),
        .rst_n(rst_n),
        .we(ram_we),
        .addr(daddr),
        .wdata(dreq.wdata),
        .q(ram_q)
    );

    always_comb begin
        next_s = s;
        next_s.rd_ack = 1'b0;
        next_s.pm_done = 1'b0;
        // program counter, interrupt over jump over step
        if (pc_ctl.irq) begin
            next_s.pc = `PDM_IRQ_VEC;
        end else if (pc_ctl.jump) begin
            next_s.pc = wrap(pc_ctl.target);
        end else if (pc_ctl.step) begin
            next_s.pc = wrap(s.pc + `PDM_PC_W'(1));
        end
        // status holds the bank bits, one register for all banks
        if (dreq.req && dreq.we && is_status) begin
            next_s.status = dreq.wdata;
        end
        // data reads: capture source, answer two cycles after the request
        next_s.rd_pend = dreq.req && !dreq.we;
        if (dreq.req && !dreq.we) begin
            if (is_gpr) begin
                next_s.rd_src = pdm_pkg::PDM_SRC_RAM;
            end else if (is_status) begin
                next_s.rd_src = pdm_pkg::PDM_SRC_STATUS;
                next_s.rd_hold = s.status;
            end else begin
                next_s.rd_src = pdm_pkg::PDM_SRC_SFR;
                next_s.rd_hold = sfr_rdata;
            end
        end
        if (s.rd_pend) begin
            next_s.rd_ack = 1'b1;
            next_s.rd_data = (s.rd_src == pdm_pkg::PDM_SRC_RAM) ? ram_q : s.rd_hold;
        end
        // program memory read port, independent of fetch
        unique case (s.pm_state)
            pdm_pkg::PDM_PM_IDLE: begin
                if (pm_req) begin
                    next_s.pm_addr = wrap(pm_rd_addr);
                    next_s.pm_state = pdm_pkg::PDM_PM_CAPTURE;
                end
            end
            pdm_pkg::PDM_PM_CAPTURE: begin
                next_s.pm_data = pm_word;
                next_s.pm_done = 1'b1;
                next_s.pm_state = pdm_pkg::PDM_PM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.pc <= `PDM_RESET_VEC;
            s.status <= `PDM_STATUS_RST;
            s.rd_pend <= 1'b0;
            s.rd_src <= pdm_pkg::PDM_SRC_RAM;
            s.rd_hold <= 8'h00;
            s.rd_ack <= 1'b0;
            s.rd_data <= 8'h00;
            s.pm_state <= pdm_pkg::PDM_PM_IDLE;
            s.pm_addr <= '0;
            s.pm_data <= '0;
            s.pm_done <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // fetch and data paths run side by side
    assign fetch_addr = s.pc;
    assign pm_addr = s.pm_addr;
    assign pm_busy = (s.pm_state == pdm_pkg::PDM_PM_CAPTURE);
    assign pm_data = s.pm_data;
    assign pm_done = s.pm_done;
    assign d_ack = s.rd_ack;
    assign d_rdata = s.rd_data;
    assign status_q = s.status;
    assign bank_select_high = s.status[`PDM_BSEL_HI];
    assign bank_select_low = s.status[`PDM_BSEL_LO];

    // checks
    property p_reset_vec;
        @(posedge clk) $rose(rst_n) |-> fetch_addr == 13'h0000;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

    property p_irq_vec;
        @(posedge clk) disable iff (!rst_n) pc_ctl.irq |=> fetch_addr == 13'h0004;
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector missed");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n) (fetch_addr & ~PC_MASK) == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pc beyond implemented memory");

    property p_step;
        @(posedge clk) disable iff (!rst_n)
            pc_ctl.step && !pc_ctl.jump && !pc_ctl.irq |=>
            fetch_addr == (($past(fetch_addr) + 13'h0001) & PC_MASK);
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong");

    property p_jump;
        @(posedge clk) disable iff (!rst_n)
            pc_ctl.jump && !pc_ctl.irq |=> fetch_addr == ($past(pc_ctl.target) & PC_MASK);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not wrapped");

    property p_bank;
        @(posedge clk) disable iff (!rst_n)
            dreq.req && !mirrored(dreq.ofs) |->
            sfr_addr == {status_q[6], status_q[5], dreq.ofs};
    endproperty
    a_bank: assert property (p_bank) else $error("bank bits not on address");

    property p_mirror;
        @(posedge clk) disable iff (!rst_n)
            dreq.req && mirrored(dreq.ofs) |-> sfr_addr[8:7] == 2'b00;
    endproperty
    a_mirror: assert property (p_mirror) else $error("alias not folded");

    property p_rd_lat;
        @(posedge clk) disable iff (!rst_n) dreq.req && !dreq.we |-> ##2 d_ack;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

    property p_status_wr;
        @(posedge clk) disable iff (!rst_n)
            dreq.req && dreq.we && is_status |=>
            {bank_select_high, bank_select_low} == $past(dreq.wdata[6:5]);
    endproperty
    a_status_wr: assert property (p_status_wr) else $error("bank select not updated");

    property p_region;
        @(posedge clk) disable iff (!rst_n)
            ram_we |-> dreq.ofs >= 7'h20 && !sfr_we && !sfr_re;
    endproperty
    a_region: assert property (p_region) else $error("ram written in special area");

    property p_pm_read;
        @(posedge clk) disable iff (!rst_n) pm_req && !pm_busy |=> pm_busy ##1 pm_done;
    endproperty
    a_pm_read: assert property (p_pm_read) else $error("program read lost");

    c_irq: cover property (@(posedge clk) disable iff (!rst_n) pc_ctl.irq ##1 pc_ctl.step);
    c_bank3: cover property (@(posedge clk) disable iff (!rst_n)
        ram_we && bank == 2'b11);
    c_mirror: cover property (@(posedge clk) disable iff (!rst_n)
        sfr_re && mirrored(dreq.ofs) && bank != 2'b00);
    c_pm: cover property (@(posedge clk) disable iff (!rst_n) pm_done && pc_ctl.step);
endmodule // pdm_map

// *** tb/pdm_core_model.sv ***
// far-side model: program memory second port and special register file
// assumes pdm_map strobes and addresses on one clock
`timescale 1ns/100ps
module pdm_core_model (
    // clock
    input wire logic clk,
    // program memory read port
    input wire logic [12:0] pm_addr,
    output logic [13:0] pm_word,
    // special register bus
    input wire logic sfr_re,
    input wire logic sfr_we,
    input wire logic [8:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata
);
    logic [7:0] regs [512];
    // word pattern that differs per address
    assign pm_word = {1'b0, pm_addr} ^ 14'h2C3A;
    // unselected bus shows inverted data, never a held value
    assign sfr_rdata = sfr_re ? regs[sfr_addr] : ~regs[sfr_addr];
    always_ff @(posedge clk) begin
        if (sfr_we) begin
            regs[sfr_addr] <= sfr_wdata;
        end
    end
endmodule // pdm_core_model

// *** tb/test_pdm_map.sv ***
// self-checking bench for the memory map block, small program variant
// assumes pdm_core_model on the far side, inputs driven at falling edge
`timescale 1ns/100ps
module test_pdm_map;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pdm_pkg::pdm_pc_ctl_t pc_ctl = '0;
    logic pm_req = 1'b0;
    logic [12:0] pm_rd_addr = '0;
    pdm_pkg::pdm_dreq_t dreq = '0;
    logic [12:0] fetch_addr, pm_addr;
    logic pm_busy, pm_done, d_ack, sfr_re, sfr_we, bsh, bsl, seen_we;
    logic [13:0] pm_word, pm_data;
    logic [7:0] d_rdata, sfr_wdata, sfr_rdata, status_q;
    logic [8:0] sfr_addr, seen_addr;
    int err_total = 0;
    int compares = 0;

    always #20 clk = ~clk;

    pdm_map #(.PROG_WORDS(4096)) u_pdm_map (
        .clk(clk), .rst_n(rst_n), .pc_ctl(pc_ctl), .fetch_addr(fetch_addr),
        .pm_req(pm_req), .pm_rd_addr(pm_rd_addr), .pm_busy(pm_busy), .pm_addr(pm_addr),
        .pm_word(pm_word), .pm_done(pm_done), .pm_data(pm_data), .dreq(dreq),
        .d_ack(d_ack), .d_rdata(d_rdata), .sfr_re(sfr_re), .sfr_we(sfr_we),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .status_q(status_q), .bank_select_high(bsh), .bank_select_low(bsl)
    );
    pdm_core_model u_pdm_core_model (
        .clk(clk), .pm_addr(pm_addr), .pm_word(pm_word), .sfr_re(sfr_re),
        .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
    );

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one pc control cycle, controls stay up until the next call
    task automatic pc_op(logic s, logic j, logic i, logic [12:0] t);
        pc_ctl = '{step: s, jump: j, irq: i, target: t};
        @(negedge clk);
    endtask

    // one data access; reads wait a bounded time for the ack
    // writes stay up until the next call replaces them
    task automatic dacc(logic we, logic [6:0] ofs, logic [7:0] wd, output logic [7:0] rd);
        dreq = '{req: 1'b1, we: we, ofs: ofs, wdata: wd};
        #5;
        seen_we = sfr_we;
        seen_addr = sfr_addr;
        @(negedge clk);
        if (!we) begin
            dreq = '0;
            for (int i = 0; i < 4 && d_ack !== 1'b1; i++) begin
                @(negedge clk);
            end
            chk("d_ack", 1'b1, d_ack);
        end
        rd = d_rdata;
    endtask

    task automatic test_pc();
        chk("fetch_addr", 13'h0000, fetch_addr);
        pc_op(1, 0, 0, 0);
        chk("fetch_addr", 13'h0001, fetch_addr);
        pc_op(0, 1, 0, 13'h0FFF);
        pc_op(1, 0, 0, 0);
        chk("fetch_addr", 13'h0000, fetch_addr);
        pc_op(0, 1, 0, 13'h1ABC);
        chk("fetch_addr", 13'h0ABC, fetch_addr);
        pc_op(1, 1, 1, 13'h0100);
        chk("fetch_addr", 13'h0004, fetch_addr);
        pc_op(1, 0, 0, 0);
        chk("fetch_addr", 13'h0005, fetch_addr);
        pc_ctl = '0;
    endtask

    task automatic test_banks();
        logic [7:0] rd;
        for (int b = 0; b < 4; b++) begin
            dacc(1, 7'h03, 8'(b << 5), rd);
            chk("bank_select", 16'(b), {bsh, bsl});
            chk("status_q", 16'(b << 5), status_q);
            dacc(1, 7'h20, 8'h50 + 8'(b), rd);
            dacc(1, 7'h05, 8'hC0 + 8'(b), rd);
            chk("sfr_we", 1'b1, seen_we);
            chk("sfr_addr", {2'(b), 7'h05}, seen_addr);
            dacc(1, 7'h0A, 8'h11 + 8'(b), rd);
            chk("alias_addr", 9'h00A, seen_addr);
        end
        dacc(1, 7'h7F, 8'h77, rd);
        for (int b = 0; b < 4; b++) begin
            dacc(1, 7'h03, 8'(b << 5), rd);
            dacc(0, 7'h20, 0, rd);
            chk("ram_read", 8'h50 + 8'(b), rd);
            dacc(0, 7'h05, 0, rd);
            chk("sfr_read", 8'hC0 + 8'(b), rd);
            dacc(0, 7'h7F, 0, rd);
            chk("common_read", 8'h77, rd);
            dacc(0, 7'h03, 0, rd);
            chk("status_read", 8'(b << 5), rd);
            dacc(0, 7'h0A, 8'h00, rd);
            chk("alias_read", 8'h14, rd);
        end
    endtask

    task automatic test_pm();
        pm_req = 1'b1;
        pm_rd_addr = 13'h1234;
        pc_ctl.step = 1'b1;
        dreq = '{req: 1'b1, we: 1'b0, ofs: 7'h20, wdata: 8'h00};
        @(negedge clk);
        pm_req = 1'b0;
        pc_ctl = '0;
        dreq = '0;
        chk("pm_busy", 1'b1, pm_busy);
        chk("pm_addr", 13'h0234, pm_addr);
        chk("fetch_addr", 13'h0006, fetch_addr);
        @(negedge clk);
        chk("pm_done", 1'b1, pm_done);
        chk("pm_data", {1'b0, 13'h0234} ^ 14'h2C3A, pm_data);
        chk("d_ack", 1'b1, d_ack);
        chk("d_rdata", 8'h53, d_rdata);
        @(negedge clk);
        chk("pm_done", 1'b0, pm_done);
    endtask

    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        test_pc();
        test_banks();
        test_pm();
        complete_run();
    end
endmodule // test_pdm_map
